// file: design/fsb_pkg.sv
// Shared constants for the framer status and interrupt mask block
package fsb_pkg;
	// ==================================================
	// Register offsets on the parallel host port
	localparam logic [7:0] FSB_OFS_A_EVENT_MASK_TWO  = 8'h6f;
	localparam logic [7:0] FSB_OFS_A_ALARM_MASK_ONE  = 8'h7f;
	localparam logic [7:0] FSB_OFS_B_EVENT_STATUS_TWO = 8'hc1;
	localparam logic [7:0] FSB_OFS_B_ALARM_MASK_ONE  = 8'hff;
	localparam logic [7:0] FSB_MASK_RESET            = 8'h00;

	// ==================================================
	// Bit positions of status register two and mask two
	localparam int FSB_BIT_RX_MF      = 7;
	localparam int FSB_BIT_TX_MF      = 6;
	localparam int FSB_BIT_TIMER      = 5;
	localparam int FSB_BIT_RX_FULL    = 4;
	localparam int FSB_BIT_TX_EMPTY   = 3;
	localparam int FSB_BIT_MATCH      = 2;
	localparam int FSB_BIT_ABORT      = 1;
	localparam logic [7:0] FSB_EVENT_BITS = 8'hfe;

	// ==================================================
	// Timer figures, derived from the receive frame period
	localparam int FSB_FRAME_US      = 125;
	localparam int FSB_LONG_MS       = 999;
	localparam int FSB_LAST_MS       = 1002;
	localparam int FSB_SHORT_MS      = 42;
	localparam int FSB_LONG_FRAMES   = FSB_LONG_MS * 1000 / FSB_FRAME_US;
	localparam int FSB_LAST_FRAMES   = FSB_LAST_MS * 1000 / FSB_FRAME_US;
	localparam int FSB_SHORT_FRAMES  = 333;
	localparam int FSB_CNT_W         = 13;
	localparam logic [1:0] FSB_LAST_PHASE = 2'h2;
	localparam logic [3:0] FSB_ABORT_ONES = 4'h8;

	typedef logic [7:0] fsb_byte_t;
endpackage

// file: design/fsb_sec_timer.sv
// Frame-counting timer: 999/999/1002 ms pattern or 333-frame (41.625 ms) ticks
`timescale 1ns/1ps
module fsb_sec_timer
	import fsb_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic frame_tick,
	input  wire logic short_interval_select,
	output logic      tick_q
);
	logic [FSB_CNT_W-1:0] count_q;
	logic [FSB_CNT_W-1:0] limit;
	logic [1:0]           phase_q;

	// ==================================================
	// Interval length
	// three second pattern
	always_comb begin
		if (short_interval_select)
			limit = FSB_CNT_W'(FSB_SHORT_FRAMES);
		else if (phase_q == FSB_LAST_PHASE)
			limit = FSB_CNT_W'(FSB_LAST_FRAMES);
		else
			limit = FSB_CNT_W'(FSB_LONG_FRAMES);
	end

	// Counts only on receive frame ticks, so a stopped line freezes it
	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= '0;
			phase_q <= '0;
			tick_q  <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (frame_tick) begin
				if (count_q >= limit - FSB_CNT_W'(1)) begin
					count_q <= '0;
					tick_q  <= 1'b1;
					if (!short_interval_select)
						phase_q <= (phase_q == FSB_LAST_PHASE) ? 2'h0
							: phase_q + 2'h1;
				end else begin
					count_q <= count_q + FSB_CNT_W'(1);
				end
			end
		end
	end

	a_short_tick_count: assert property (
		@(posedge clk) disable iff (srst)
		(frame_tick && short_interval_select
		&& count_q == FSB_CNT_W'(FSB_SHORT_FRAMES - 1)) |=> tick_q)
		else $error("short interval tick missing");
	a_phase_range: assert property (
		@(posedge clk) disable iff (srst)
		phase_q <= FSB_LAST_PHASE)
		else $error("timer phase out of range");
	a_last_interval: assert property (
		@(posedge clk) disable iff (srst)
		(frame_tick && !short_interval_select && phase_q == FSB_LAST_PHASE
		&& count_q == FSB_CNT_W'(FSB_LAST_FRAMES - 1))
		|=> tick_q && phase_q == 2'h0)
		else $error("long interval did not wrap");
endmodule

// file: design/fsb_top.sv
// Framer B status register two and framer interrupt masks
`timescale 1ns/1ps
module fsb_top
	import fsb_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire logic [7:0]     host_addr,
	input  wire logic           host_wr,
	input  wire logic           host_rd,
	input  wire fsb_pkg::fsb_byte_t host_wdata,
	output fsb_pkg::fsb_byte_t  host_rdata_q,
	input  wire logic           rx_frame_tick,
	input  wire logic           rx_mf_boundary,
	input  wire logic           tx_mf_boundary,
	input  wire logic           short_interval_select,
	input  wire logic           rx_link_bit_valid,
	input  wire logic           rx_link_bit,
	input  wire logic           rx_link_byte_valid,
	input  wire fsb_pkg::fsb_byte_t rx_link_byte,
	input  wire fsb_pkg::fsb_byte_t link_match_value_one,
	input  wire fsb_pkg::fsb_byte_t link_match_value_two,
	input  wire logic           tx_link_empty,
	input  wire fsb_pkg::fsb_byte_t framer_a_alarm_status,
	input  wire fsb_pkg::fsb_byte_t framer_b_alarm_status,
	input  wire fsb_pkg::fsb_byte_t framer_a_event_status,
	input  wire fsb_pkg::fsb_byte_t framer_b_event_mask_two,
	output logic                irq_a_q,
	output logic                irq_b_q
);
	import fsb_pkg::*;

	fsb_byte_t  status_q;
	fsb_byte_t  events;
	fsb_byte_t  a_event_mask_q;
	fsb_byte_t  a_alarm_mask_q;
	fsb_byte_t  b_alarm_mask_q;
	fsb_byte_t  rd_mux;
	logic [3:0] ones_q;
	logic       tx_empty_q;
	logic       timer_tick;
	logic       rd_status;

	// ==================================================
	// Timer
	fsb_sec_timer u_timer (
		.clk                  (clk),
		.srst                 (srst),
		.frame_tick           (rx_frame_tick),
		.short_interval_select(short_interval_select),
		.tick_q               (timer_tick)
	);

	// ==================================================
	// Event detection
	always_ff @(posedge clk) begin
		if (srst) begin
			ones_q     <= '0;
			tx_empty_q <= 1'b1;
		end else begin
			tx_empty_q <= tx_link_empty;
			if (rx_link_bit_valid)
				ones_q <= !rx_link_bit ? 4'h0
					: (ones_q == FSB_ABORT_ONES) ? ones_q : ones_q + 4'h1;
		end
	end

	always_comb begin
		events = '0;
		events[FSB_BIT_RX_MF]    = rx_mf_boundary;
		events[FSB_BIT_TX_MF]    = tx_mf_boundary;
		events[FSB_BIT_TIMER]    = timer_tick;
		events[FSB_BIT_RX_FULL]  = rx_link_byte_valid;
		events[FSB_BIT_TX_EMPTY] = tx_link_empty && !tx_empty_q;
		events[FSB_BIT_MATCH]    = rx_link_byte_valid
			&& (rx_link_byte == link_match_value_one
			|| rx_link_byte == link_match_value_two);
		events[FSB_BIT_ABORT]    = rx_link_bit_valid && rx_link_bit
			&& ones_q == FSB_ABORT_ONES - 4'h1;
	end

	// ==================================================
	// Sticky status, cleared by reading it; a new event wins
	assign rd_status = host_rd && host_addr == FSB_OFS_B_EVENT_STATUS_TWO;

	always_ff @(posedge clk) begin
		if (srst)
			status_q <= '0;
		else if (rd_status)
			status_q <= events;
		else
			status_q <= status_q | events;
	end

	// ==================================================
	// Mask registers
	// mask one and mask two layout
	always_ff @(posedge clk) begin
		if (srst) begin
			a_event_mask_q <= FSB_MASK_RESET;
			a_alarm_mask_q <= FSB_MASK_RESET;
			b_alarm_mask_q <= FSB_MASK_RESET;
		end else if (host_wr) begin
			if (host_addr == FSB_OFS_A_EVENT_MASK_TWO)
				a_event_mask_q <= host_wdata;
			if (host_addr == FSB_OFS_A_ALARM_MASK_ONE)
				a_alarm_mask_q <= host_wdata;
			if (host_addr == FSB_OFS_B_ALARM_MASK_ONE)
				b_alarm_mask_q <= host_wdata;
		end
	end

	// ==================================================
	// Read port; unassigned bit 0 of status reads as zero
	always_comb begin
		unique case (host_addr)
			FSB_OFS_A_EVENT_MASK_TWO:   rd_mux = a_event_mask_q;
			FSB_OFS_A_ALARM_MASK_ONE:   rd_mux = a_alarm_mask_q;
			FSB_OFS_B_EVENT_STATUS_TWO: rd_mux = status_q & FSB_EVENT_BITS;
			FSB_OFS_B_ALARM_MASK_ONE:   rd_mux = b_alarm_mask_q;
			default:                    rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			host_rdata_q <= '0;
		else if (host_rd)
			host_rdata_q <= rd_mux;
	end

	// ==================================================
	// Interrupt gating
	// mask gates interrupt
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
		end else begin
			irq_a_q <= |(framer_a_alarm_status & a_alarm_mask_q)
				| |(framer_a_event_status & a_event_mask_q & FSB_EVENT_BITS);
			irq_b_q <= |(framer_b_alarm_status & b_alarm_mask_q)
				| |(status_q & framer_b_event_mask_two & FSB_EVENT_BITS);
		end
	end

	// ==================================================
	// Checks
	sequence s_read_status;
		host_rd && host_addr == FSB_OFS_B_EVENT_STATUS_TWO;
	endsequence

	// A zero restarts the run, so the eighth one is a fresh abort
	sequence s_zero_then_eight_ones;
		(rx_link_bit_valid && !rx_link_bit)
		##1 (rx_link_bit_valid && rx_link_bit)[*8];
	endsequence

	a_rx_mf_flag: assert property (
		@(posedge clk) disable iff (srst)
		rx_mf_boundary |=> status_q[FSB_BIT_RX_MF])
		else $error("rx multiframe flag not set");
	a_tx_mf_flag: assert property (
		@(posedge clk) disable iff (srst)
		tx_mf_boundary |=> status_q[FSB_BIT_TX_MF])
		else $error("tx multiframe flag not set");
	a_timer_flag: assert property (
		@(posedge clk) disable iff (srst)
		timer_tick |=> status_q[FSB_BIT_TIMER])
		else $error("timer flag not set");
	a_match_flag: assert property (
		@(posedge clk) disable iff (srst)
		(rx_link_byte_valid && rx_link_byte == link_match_value_two)
		|=> status_q[FSB_BIT_MATCH])
		else $error("match flag not set");
	a_mask_blocks: assert property (
		@(posedge clk) disable iff (srst)
		(a_alarm_mask_q == 8'h00 && a_event_mask_q == 8'h00)
		|=> !irq_a_q)
		else $error("masked interrupt raised");
	a_mask_passes: assert property (
		@(posedge clk) disable iff (srst)
		(framer_b_alarm_status[0] && b_alarm_mask_q[0]) |=> irq_b_q)
		else $error("enabled sync loss did not interrupt");
	a_abort_ones: assert property (
		@(posedge clk) disable iff (srst)
		s_zero_then_eight_ones |=> status_q[FSB_BIT_ABORT])
		else $error("abort flag missed eight ones");
	a_empty_edge: assert property (
		@(posedge clk) disable iff (srst)
		($rose(tx_link_empty) && !rd_status)
		|=> status_q[FSB_BIT_TX_EMPTY])
		else $error("tx empty flag not set");
	a_status_clear: assert property (
		@(posedge clk) disable iff (srst)
		(s_read_status ##0 events == 8'h00) |=> status_q == 8'h00)
		else $error("status not cleared by read");
endmodule

// file: verification/tb_framer_status_irq_mask.sv
// Self-checking bench for the framer status and interrupt mask block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("wrong value at %0t: got %h expected %h", \
			$time, got, exp); \
	end \
end
module tb_framer_status_irq_mask;
	import fsb_pkg::*;
	logic      clk = 1'b0;
	logic      srst, host_wr, host_rd, rx_frame_tick, rx_mf_boundary;
	logic      tx_mf_boundary, short_interval_select, rx_link_bit_valid;
	logic      rx_link_bit, rx_link_byte_valid, tx_link_empty, irq_a_q, irq_b_q;
	logic [7:0] host_addr;
	fsb_byte_t host_wdata, host_rdata_q, rx_link_byte, link_match_value_one;
	fsb_byte_t link_match_value_two, framer_a_alarm_status, framer_b_alarm_status;
	fsb_byte_t framer_a_event_status, framer_b_event_mask_two, d, m1a, m1b, m2a;
	fsb_byte_t regs [5] = '{8'h6f, 8'h7f, 8'hc1, 8'hff, 8'h00};
	int        seed = 25968;
	int        n_fail = 0;
	int        comparisons = 0;
	int        n, total;
	logic      e_irq;

	fsb_top dut_u (.*);

	always #4 clk = ~clk;

	// ==================================================
	// Bus and wait helpers, inputs move 1 ns after the edge
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input fsb_byte_t a, input fsb_byte_t v);
		host_addr = a;
		host_wdata = v;
		host_wr = 1'b1;
		tick(1);
		host_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input fsb_byte_t a, output fsb_byte_t v);
		host_addr = a;
		host_rd = 1'b1;
		tick(1);
		host_rd = 1'b0;
		v = host_rdata_q;
		tick(1);
	endtask
	task automatic chk_st(input fsb_byte_t e);
		fsb_byte_t v;
		rd(FSB_OFS_B_EVENT_STATUS_TWO, v);
		`CHK(v, e)
	endtask
	// Valid stays high across back-to-back runs; the caller drops it
	task automatic bits(input int k, input logic b);
		rx_link_bit_valid = 1'b1;
		rx_link_bit = b;
		tick(k);
	endtask
	// Interval from rise to rise: read, its idle edge and one more add three
	task automatic wait_irq(output int k);
		fsb_byte_t v;
		k = 0;
		while (irq_b_q !== 1'b1 && k < 9000) begin
			tick(1);
			k++;
		end
		if (k >= 9000) begin
			n_fail++;
			conclude();
		end
		rd(FSB_OFS_B_EVENT_STATUS_TWO, v);
		`CHK(v, 8'h20)
		tick(1);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==================================================
	// Main sequence
	initial begin
		{srst, tx_link_empty} = 2'b11;
		{host_wr, host_rd, rx_frame_tick, rx_mf_boundary, tx_mf_boundary} = '0;
		{short_interval_select, rx_link_bit_valid, rx_link_bit} = '0;
		{rx_link_byte_valid, host_addr, host_wdata, rx_link_byte} = '0;
		{link_match_value_one, link_match_value_two} = '0;
		{framer_a_alarm_status, framer_b_alarm_status} = '0;
		{framer_a_event_status, framer_b_event_mask_two} = '0;
		tick(10);
		srst = 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], d);
			`CHK(d, 8'h00)
		end
		$display("test reset done");
		// masks gate alarms and framer A events
		for (int i = 0; i < 16; i++) begin
			m1a = 8'h01 << (i % 8);
			m1b = (i < 8) ? ~m1a : $random(seed);
			m2a = $random(seed) & FSB_EVENT_BITS;
			wr(FSB_OFS_A_ALARM_MASK_ONE, m1a);
			wr(FSB_OFS_B_ALARM_MASK_ONE, m1b);
			wr(FSB_OFS_A_EVENT_MASK_TWO, m2a);
			framer_a_alarm_status = $random(seed);
			framer_b_alarm_status = $random(seed);
			framer_a_event_status = $random(seed);
			framer_b_event_mask_two = $random(seed);
			tick(3);
			e_irq = |(framer_a_alarm_status & m1a)
				| |(framer_a_event_status & m2a & FSB_EVENT_BITS);
			`CHK(irq_a_q, e_irq)
			`CHK(irq_b_q, |(framer_b_alarm_status & m1b))
			rd(FSB_OFS_A_ALARM_MASK_ONE, d);
			`CHK(d, m1a)
			rd(FSB_OFS_B_ALARM_MASK_ONE, d);
			`CHK(d, m1b)
			rd(FSB_OFS_A_EVENT_MASK_TWO, d);
			`CHK(d, m2a)
		end
		{framer_a_alarm_status, framer_b_alarm_status} = '0;
		wr(FSB_OFS_B_EVENT_STATUS_TWO, 8'hff);
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		`CHK(d, 8'h00)
		chk_st(8'h00);
		$display("test masks done");
		// multiframe flags, only receive bit enabled
		framer_b_event_mask_two = 8'h80;
		rx_mf_boundary = 1'b1;
		tick(1);
		rx_mf_boundary = 1'b0;
		tick(2);
		`CHK(irq_b_q, 1'b1)
		chk_st(8'h80);
		tx_mf_boundary = 1'b1;
		tick(1);
		tx_mf_boundary = 1'b0;
		tick(2);
		`CHK(irq_b_q, 1'b0)
		chk_st(8'h40);
		// received link bytes against both match values
		link_match_value_one = $random(seed);
		link_match_value_two = link_match_value_one ^ 8'h5a;
		for (int i = 0; i < 3; i++) begin
			rx_link_byte = (i == 0) ? link_match_value_one :
				(i == 1) ? link_match_value_one ^ 8'h01 : link_match_value_two;
			rx_link_byte_valid = 1'b1;
			tick(1);
			rx_link_byte_valid = 1'b0;
			tick(1);
			chk_st((i == 1) ? 8'h10 : 8'h14);
		end
		// abort needs eight ones in a row and does not repeat
		bits(7, 1'b1);
		bits(1, 1'b0);
		bits(7, 1'b1);
		rx_link_bit_valid = 1'b0;
		tick(1);
		chk_st(8'h00);
		bits(1, 1'b1);
		rx_link_bit_valid = 1'b0;
		tick(1);
		chk_st(8'h02);
		bits(3, 1'b1);
		rx_link_bit_valid = 1'b0;
		tick(1);
		chk_st(8'h00);
		bits(1, 1'b0);
		bits(8, 1'b1);
		rx_link_bit_valid = 1'b0;
		tick(1);
		chk_st(8'h02);
		tx_link_empty = 1'b0;
		tick(2);
		chk_st(8'h00);
		tx_link_empty = 1'b1;
		tick(2);
		chk_st(8'h08);
		$display("test events done");
		// timer, one frame per clock to keep the run short
		framer_b_event_mask_two = 8'h20;
		rx_frame_tick = 1'b1;
		wait_irq(n);
		total = 0;
		repeat (3) begin
			wait_irq(n);
			`CHK((n + 3 == 7992) || (n + 3 == 8016), 1'b1)
			total += n + 3;
		end
		`CHK(total, 24000)
		short_interval_select = 1'b1;
		wait_irq(n);
		repeat (2) begin
			wait_irq(n);
			`CHK(n + 3, 333)
		end
		$display("test timer done");
		conclude();
	end
endmodule
